//--- rtl/exca_gctl_pkg.sv
// constants and types for the socket global control register slice
//
// Functional notes
// - global control bits 7-5 read zero
// - bit 4 card B edge/level signalling
// - bit 3 card A edge/level signalling
// - bit 2 read-clear or write-one-clear flags
// - bit 1 status change edge/level signalling
// - sleep: card outputs floating except active cycle
// - sleep still takes interrupts; access wakes
// - bits 2-0 cleared only by global reset
// - window 0/1 offset low bytes at 36h/38h
// - offset low bit 0 reads zero, rest writable
// - write-one clear of card detect clears software bit
package exca_gctl_pkg;

    // byte offsets from the socket base
    localparam logic [11:0] OFS_STATUS_CHANGE = 12'h804;
    localparam logic [11:0] OFS_CARD_DETECT   = 12'h816;
    localparam logic [11:0] OFS_GLOBAL_CTRL   = 12'h81e;
    localparam logic [11:0] OFS_IO_WIN0_LOW   = 12'h836;
    localparam logic [11:0] OFS_IO_WIN1_LOW   = 12'h838;

    // reset values
    localparam logic [7:0] GCTL_RESET   = 8'h00;
    localparam logic [7:0] IOWIN_RESET  = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // writable bits
    localparam logic [7:0] IOWIN_WMASK  = 8'hfe;

    // field positions
    localparam int SLEEP_BIT       = 0;
    localparam int CSC_SIG_BIT     = 1;
    localparam int FLAG_CLEAR_BIT  = 2;
    localparam int CARD_A_BIT      = 3;
    localparam int CARD_B_BIT      = 4;
    localparam int CSC_DETECT_BIT  = 3;
    localparam int SW_DETECT_BIT   = 5;
    localparam int CSC_FLAGS       = 4;

    // global control fields, bit 4 down to bit 0
    typedef struct packed {
        logic second_card_irq_signalling;
        logic first_card_irq_signalling;
        logic flag_clear_method;
        logic status_change_irq_signalling;
        logic card_interface_sleep;
    } gctl_t;

    // one register access from the host side
    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } reg_req_t;

    // card interface cycle state
    typedef enum logic [0:0] {
        CYC_IDLE   = 1'b0,
        CYC_ACTIVE = 1'b1
    } cyc_state_t;

endpackage

//--- rtl/socket_global_control_regs.sv
// socket global control, status change flags and io window offset low bytes
`timescale 1ns/100ps
`default_nettype none
module socket_global_control_regs #(
    parameter int CSC_W = exca_gctl_pkg::CSC_FLAGS
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_global_reset_n,
    input  wire exca_gctl_pkg::reg_req_t i_reg_req,
    input  wire logic [CSC_W-1:0]        i_csc_event,
    input  wire logic                    i_card_detect_enable,
    input  wire logic                    i_card_cycle_req,
    input  wire logic                    i_card_cycle_done,
    output logic [7:0]                   o_reg_rdata,
    output logic                         o_reg_rvalid,
    output logic                         o_second_card_level,
    output logic                         o_first_card_level,
    output logic                         o_status_change_level,
    output logic                         o_status_change_pending,
    output logic                         o_sw_card_detect_irq,
    output logic                         o_card_out_en,
    output logic [7:0]                   o_io_win0_low,
    output logic [7:0]                   o_io_win1_low
);

    // width of the implemented global control fields
    localparam int GCTL_W = $bits(exca_gctl_pkg::gctl_t);

    // address compare used by every decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // write strobe aimed at one byte offset
    function automatic logic wr_hit(input exca_gctl_pkg::reg_req_t r, input logic [11:0] ofs);
        wr_hit = r.wr && hit(r.addr, ofs);
    endfunction

    // read strobe aimed at one byte offset
    function automatic logic rd_hit(input exca_gctl_pkg::reg_req_t r, input logic [11:0] ofs);
        rd_hit = r.rd && hit(r.addr, ofs);
    endfunction

    // global control as a byte, bits 7-5 forced low
    function automatic logic [7:0] gctl_byte(input exca_gctl_pkg::gctl_t g);
        gctl_byte = {{(8 - GCTL_W){1'b0}}, g};
    endfunction

    // window offset low byte as stored, bit 0 never kept
    function automatic logic [7:0] win_byte(input logic [7:0] d);
        win_byte = d & exca_gctl_pkg::IOWIN_WMASK;
    endfunction

    // global reset synchroniser
    logic                  global_reset_meta;        // first synchroniser stage
    logic                  next_global_reset_meta;   // pin value to capture
    logic                  global_reset_sync_n;      // synchronised global reset
    logic                  next_global_reset_sync_n; // first stage moved on

    // register contents
    exca_gctl_pkg::gctl_t  gctl;           // global control fields
    exca_gctl_pkg::gctl_t  next_gctl;      // global control next value
    logic [7:0]            iow0;           // window 0 offset low
    logic [7:0]            next_iow0;      // window 0 next value
    logic [7:0]            iow1;           // window 1 offset low
    logic [7:0]            next_iow1;      // window 1 next value

    // status change flags
    logic [CSC_W-1:0]      card_status_change_register;            // status change flags
    logic [CSC_W-1:0]      next_csc;       // flags after set and clear
    logic                  pend;           // any flag set
    logic                  next_pend;      // any flag set next cycle
    logic                  sw_cd;          // software card detect request
    logic                  next_sw_cd;     // request next value

    // read answer
    logic [7:0]            rdata;          // read byte held for the host
    logic [7:0]            next_rdata;     // byte selected by the read
    logic                  rvalid;         // read answer strobe
    logic                  next_rvalid;    // strobe next value

    // card interface
    exca_gctl_pkg::cyc_state_t cyc;        // card cycle state
    exca_gctl_pkg::cyc_state_t next_cyc;   // card cycle next state
    logic                  out_en;         // card outputs driven
    logic                  next_out_en;    // drive decision next cycle

    // decoded host accesses
    logic                  wr_gctl;        // write of global control
    logic                  wr_csc;         // write of status change flags
    logic                  rd_csc;         // read of status change flags
    logic                  wr_cd;          // write of card detect control
    logic                  wr_win0;        // write of window 0 low byte
    logic                  wr_win1;        // write of window 1 low byte

    // global reset pin passes two flops before use; no reset on
    // these stages, the pin itself is the reset they carry
    always_comb begin
        next_global_reset_meta   = i_global_reset_n;
        next_global_reset_sync_n = global_reset_meta;
    end

    // synchroniser stages
    always_ff @(posedge i_clk) begin
        global_reset_meta   <= next_global_reset_meta;
        global_reset_sync_n <= next_global_reset_sync_n;
    end

    // access decodes
    always_comb begin
        // one strobe per cycle, so at most one of these is high
        wr_gctl = wr_hit(i_reg_req, exca_gctl_pkg::OFS_GLOBAL_CTRL);
        wr_csc  = wr_hit(i_reg_req, exca_gctl_pkg::OFS_STATUS_CHANGE);
        rd_csc  = rd_hit(i_reg_req, exca_gctl_pkg::OFS_STATUS_CHANGE);
        wr_cd   = wr_hit(i_reg_req, exca_gctl_pkg::OFS_CARD_DETECT);
        wr_win0 = wr_hit(i_reg_req, exca_gctl_pkg::OFS_IO_WIN0_LOW);
        wr_win1 = wr_hit(i_reg_req, exca_gctl_pkg::OFS_IO_WIN1_LOW);
    end

    // global control next value
    always_comb begin
        next_gctl = gctl;
        if (wr_gctl) begin
            next_gctl = i_reg_req.wdata[GCTL_W-1:0];
        end
        if (!i_rst_n) begin
            // bus reset clears only the interrupt mode bits of cards
            // sleep, clear method and change mode are kept
            next_gctl.second_card_irq_signalling = 1'b0;
            next_gctl.first_card_irq_signalling  = 1'b0;
        end
        if (!global_reset_sync_n) begin
            next_gctl = exca_gctl_pkg::GCTL_RESET[GCTL_W-1:0];
        end
    end

    // global control register, bus reset handled in next value
    always_ff @(posedge i_clk) begin
        gctl <= next_gctl;
    end

    // io window offset low bytes
    always_comb begin
        next_iow0 = iow0;
        next_iow1 = iow1;
        // two byte registers at their socket offsets
        if (wr_win0) begin
            // window 0 takes the written byte
            next_iow0 = win_byte(i_reg_req.wdata);
        end
        if (wr_win1) begin
            // window 1 takes the written byte
            next_iow1 = win_byte(i_reg_req.wdata);
        end
    end

    // bit 0 masked, reset to zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            // bus reset returns both bytes to zero
            iow0 <= exca_gctl_pkg::IOWIN_RESET;
            iow1 <= exca_gctl_pkg::IOWIN_RESET;
        end else begin
            // hold or take the written byte
            iow0 <= next_iow0;
            iow1 <= next_iow1;
        end
    end

    // status change flags and software card detect
    always_comb begin
        next_csc   = card_status_change_register;
        next_sw_cd = sw_cd;
        // clearing method follows the flag clear field
        if (gctl.flag_clear_method) begin
            // write-one-clear mode: only written ones clear
            if (wr_csc) begin
                next_csc = card_status_change_register & ~i_reg_req.wdata[CSC_W-1:0];
                // clearing card detect clears the software request
                if (i_reg_req.wdata[exca_gctl_pkg::CSC_DETECT_BIT]) begin
                    next_sw_cd = 1'b0;
                end
            end
        end else if (rd_csc) begin
            // cleared in the cycle the value is returned
            next_csc = '0;
        end
        // software card detect raises a card detect change
        if (wr_cd && i_reg_req.wdata[exca_gctl_pkg::SW_DETECT_BIT] && i_card_detect_enable) begin
            next_sw_cd = 1'b1;
            next_csc[exca_gctl_pkg::CSC_DETECT_BIT] = 1'b1;
        end
        // events taken even while asleep; set wins over clear
        next_csc = next_csc | i_csc_event;
        // summary is registered too, so the pending output is a flop
        next_pend = |next_csc;
    end

    // flag registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            // bus reset drops every flag and the software request
            card_status_change_register   <= '0;
            pend  <= 1'b0;
            sw_cd <= 1'b0;
        end else begin
            card_status_change_register   <= next_csc;
            pend  <= next_pend;
            sw_cd <= next_sw_cd;
        end
    end

    // read data, answered one cycle after the read strobe
    always_comb begin
        next_rvalid = i_reg_req.rd;
        next_rdata  = exca_gctl_pkg::READ_ZERO;
        if (i_reg_req.rd) begin
            if (hit(i_reg_req.addr, exca_gctl_pkg::OFS_GLOBAL_CTRL)) begin
                next_rdata = gctl_byte(gctl);
            end else if (hit(i_reg_req.addr, exca_gctl_pkg::OFS_IO_WIN0_LOW)) begin
                // stored byte, bit 0 already zero
                next_rdata = iow0;
            end else if (hit(i_reg_req.addr, exca_gctl_pkg::OFS_IO_WIN1_LOW)) begin
                // window 1 stored byte
                next_rdata = iow1;
            end else if (rd_csc) begin
                // flags as they stood before this read, cleared by it in read-clear mode only
                next_rdata = {{(8 - CSC_W){1'b0}}, card_status_change_register};
            end else begin
                // unmapped or write-only bytes read zero
                next_rdata = exca_gctl_pkg::READ_ZERO;
            end
        end
    end

    // read answer registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            // no answer pending after bus reset
            rdata  <= exca_gctl_pkg::READ_ZERO;
            rvalid <= 1'b0;
        end else begin
            // answer stands for one cycle
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // card cycle tracking and output enable
    always_comb begin
        next_cyc = cyc;
        unique case (cyc)
            exca_gctl_pkg::CYC_IDLE: begin
                // only a real access wakes the interface
                if (i_card_cycle_req) begin
                    next_cyc = exca_gctl_pkg::CYC_ACTIVE;
                end
            end
            exca_gctl_pkg::CYC_ACTIVE: begin
                // done from the card closes the cycle
                if (i_card_cycle_done) begin
                    next_cyc = exca_gctl_pkg::CYC_IDLE;
                end
            end
        endcase
        // asleep, drive only during an active cycle
        next_out_en = !gctl.card_interface_sleep
                      || (next_cyc == exca_gctl_pkg::CYC_ACTIVE);
    end

    // cycle state registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            // outputs float while bus reset holds
            cyc    <= exca_gctl_pkg::CYC_IDLE;
            out_en <= 1'b0;
        end else begin
            // track the cycle and the drive decision
            cyc    <= next_cyc;
            out_en <= next_out_en;
        end
    end

    // outputs straight from flops
    always_comb begin
        o_reg_rdata             = rdata;
        o_reg_rvalid            = rvalid;
        o_second_card_level     = gctl.second_card_irq_signalling;
        o_first_card_level      = gctl.first_card_irq_signalling;
        o_status_change_level   = gctl.status_change_irq_signalling;
        // flag summary and software request
        o_status_change_pending = pend;
        o_sw_card_detect_irq    = sw_cd;
        o_card_out_en           = out_en;
        // window offset low bytes as stored
        o_io_win0_low           = iow0;
        o_io_win1_low           = iow1;
    end

endmodule
`default_nettype wire

//--- testbench/exca_gctl_asserts.sv
// assertion checker for the global control register slice
`timescale 1ns/100ps
`default_nettype none
module exca_gctl_asserts #(
    parameter int CSC_W = 4
) (
    input wire logic                    i_clk,
    input wire logic                    i_rst_n,
    input wire exca_gctl_pkg::reg_req_t i_reg_req,
    input wire logic [CSC_W-1:0]        i_csc_event,
    input wire logic                    i_card_cycle_req,
    input wire logic [7:0]              o_reg_rdata,
    input wire logic                    o_reg_rvalid,
    input wire logic                    o_second_card_level,
    input wire logic                    o_first_card_level,
    input wire logic                    o_status_change_level,
    input wire logic                    o_status_change_pending,
    input wire logic                    o_card_out_en,
    input wire logic [7:0]              o_io_win0_low,
    input wire logic [7:0]              o_io_win1_low
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // decoded accesses
    wire logic gw = i_reg_req.wr && i_reg_req.addr == exca_gctl_pkg::OFS_GLOBAL_CTRL;
    wire logic gr = i_reg_req.rd && i_reg_req.addr == exca_gctl_pkg::OFS_GLOBAL_CTRL;
    wire logic ww = i_reg_req.wr && i_reg_req.addr == exca_gctl_pkg::OFS_IO_WIN0_LOW;
    AST_RD_LAT: assert property (i_reg_req.rd |=> o_reg_rvalid)
        else $error("read answer late");
    AST_GCTL_HI: assert property (gr |=> o_reg_rdata[7:5] == 3'h0)
        else $error("global control top bits set");
    AST_CARD_B: assert property (gw |=> o_second_card_level == $past(i_reg_req.wdata[4]))
        else $error("card b mode wrong");
    AST_CARD_A: assert property (gw |=> o_first_card_level == $past(i_reg_req.wdata[3]))
        else $error("card a mode wrong");
    AST_CSC_SIG: assert property (gw |=> o_status_change_level == $past(i_reg_req.wdata[1]))
        else $error("status change mode wrong");
    AST_WIN_LSB: assert property (!o_io_win0_low[0] && !o_io_win1_low[0])
        else $error("window bit 0 set");
    AST_WIN0_WR: assert property (ww |=> (o_io_win0_low & 8'hfe) == ($past(i_reg_req.wdata) & 8'hfe))
        else $error("window 0 write lost");
    AST_EVT_PEND: assert property (|i_csc_event |=> o_status_change_pending)
        else $error("event not pending");
    AST_WAKE: assert property (i_card_cycle_req && !o_card_out_en |=> o_card_out_en)
        else $error("card cycle did not wake outputs");
    // main scenarios
    cover property (gw);
    cover property (i_reg_req.rd && o_status_change_pending);
    cover property (i_card_cycle_req && !o_card_out_en);
endmodule
bind socket_global_control_regs exca_gctl_asserts #(.CSC_W(CSC_W)) u_asserts (.*);
`default_nettype wire

//--- testbench/card_socket_model.sv
// behavioural card socket answering card access cycles
`timescale 1ns/100ps
`default_nettype none
module card_socket_model (
    input  wire logic i_clk,
    input  wire logic i_out_en,
    output var logic  o_req,
    output var logic  o_done
);
    initial begin
        o_req  = 1'b0;
        o_done = 1'b0;
    end
    // request, wait for driven outputs, hold, then finish
    task automatic access(input int hold);
        @(posedge i_clk) #1 o_req = 1'b1;
        @(posedge i_clk) #1 o_req = 1'b0;
        while (i_out_en !== 1'b1) @(posedge i_clk);
        repeat (hold) @(posedge i_clk);
        #1 o_done = 1'b1;
        @(posedge i_clk) #1 o_done = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/socket_global_control_regs_test.sv
// self-checking bench for the global control register slice
`timescale 1ns/100ps
`default_nettype none
module socket_global_control_regs_test;
    localparam logic [11:0] GC = exca_gctl_pkg::OFS_GLOBAL_CTRL;
    localparam logic [11:0] CS = exca_gctl_pkg::OFS_STATUS_CHANGE;
    localparam logic [11:0] CD = exca_gctl_pkg::OFS_CARD_DETECT;
    logic                    i_clk = 1'b0;
    logic                    i_rst_n = 1'b0;
    logic                    global_reset_n = 1'b0;
    logic                    cd_en = 1'b0;
    logic [3:0]              ev = 4'h0;
    exca_gctl_pkg::reg_req_t req = '0;
    logic                    c_req, c_done, rvalid, lb, la, lc, pend, swirq, oen;
    logic [7:0]              rdata, w0, w1;
    int                      err_total, checks_done, cyc;
    socket_global_control_regs DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_global_reset_n(global_reset_n),
        .i_reg_req(req), .i_csc_event(ev), .i_card_detect_enable(cd_en),
        .i_card_cycle_req(c_req), .i_card_cycle_done(c_done), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_second_card_level(lb), .o_first_card_level(la),
        .o_status_change_level(lc), .o_status_change_pending(pend),
        .o_sw_card_detect_irq(swirq), .o_card_out_en(oen), .o_io_win0_low(w0),
        .o_io_win1_low(w1));
    card_socket_model card (.i_clk(i_clk), .i_out_en(oen), .o_req(c_req), .o_done(c_done));
    always #50 i_clk = ~i_clk;
    // hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude;
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic ok);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t ns: output mismatch", $time);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk) #1 req = '{a, 1'b1, 1'b0, d};
        @(posedge i_clk) #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clk) #1 req = '{a, 1'b0, 1'b1, 8'h00};
        @(posedge i_clk) #1 req.rd = 1'b0;
        chk(rvalid === 1'b1 && rdata === e);
    endtask
    task automatic evt(input logic [3:0] v);
        @(posedge i_clk) #1 ev = v;
        @(posedge i_clk) #1 ev = 4'h0;
    endtask
    // mode bits, reserved top bits
    task automatic t_gctl;
        wr(GC, 8'hff);
        rd(GC, 8'h1f);
        wr(GC, 8'h12);
        chk(lb === 1'b1 && la === 1'b0 && lc === 1'b1);
        wr(GC, 8'h08);
        chk(lb === 1'b0 && la === 1'b1 && lc === 1'b0);
    endtask
    // window bytes, unmapped read, two resets
    task automatic t_win_rst;
        wr(exca_gctl_pkg::OFS_IO_WIN0_LOW, 8'hff);
        chk(w0 === 8'hfe);
        wr(exca_gctl_pkg::OFS_IO_WIN1_LOW, 8'h55);
        rd(exca_gctl_pkg::OFS_IO_WIN1_LOW, 8'h54);
        @(posedge i_clk) #1 chk(rvalid === 1'b0 && rdata === 8'h00);
        rd(12'h900, 8'h00);
        wr(GC, 8'h1e);
        @(posedge i_clk) #1 i_rst_n = 1'b0;
        @(posedge i_clk) #1 i_rst_n = 1'b1;
        rd(GC, 8'h06);
        chk(w0 === 8'h00 && w1 === 8'h00);
        global_reset_n = 1'b0;
        repeat (4) @(posedge i_clk);
        #1 global_reset_n = 1'b1;
        rd(GC, 8'h00);
    endtask
    // read-clear, event during read survives
    task automatic t_rdclr;
        evt(4'h2);
        chk(pend === 1'b1);
        fork
            rd(CS, 8'h02);
            evt(4'h4);
        join
        chk(pend === 1'b1);
        rd(CS, 8'h04);
        chk(pend === 1'b0);
    endtask
    // write-one-clear and software card detect
    task automatic t_wrclr;
        wr(GC, 8'h04);
        evt(4'h1);
        rd(CS, 8'h01);
        wr(CS, 8'h01);
        chk(pend === 1'b0);
        wr(CD, 8'h20);
        chk(swirq === 1'b0);
        cd_en = 1'b1;
        wr(CD, 8'h20);
        chk(swirq === 1'b1 && pend === 1'b1);
        wr(CS, 8'h08);
        chk(swirq === 1'b0 && pend === 1'b0);
    endtask
    // sleep: outputs float except during a card cycle
    task automatic t_sleep;
        chk(oen === 1'b1);
        wr(GC, 8'h01);
        @(posedge i_clk) #1 chk(oen === 1'b0);
        evt(4'h8);
        chk(pend === 1'b1 && oen === 1'b0);
        fork
            card.access(3);
            begin
                repeat (3) @(posedge i_clk);
                #1 chk(oen === 1'b1);
            end
        join
        chk(oen === 1'b0);
        rd(CS, 8'h08);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        global_reset_n = 1'b1;
        rd(GC, 8'h00);
        rd(exca_gctl_pkg::OFS_IO_WIN0_LOW, 8'h00);
        t_gctl();
        t_win_rst();
        t_rdclr();
        t_wrclr();
        wr(GC, 8'h00);
        t_sleep();
        conclude();
    end
endmodule
`default_nettype wire
